// *** hw/cap_pkg.sv ***
package cap_pkg;
    localparam int CAP_MODULES = 5;
    localparam int CAP_WDOG_MODULE = 4;
    localparam logic [7:0] CAP_ADDR_CTRL = 8'hD8;
    localparam logic [7:0] CAP_ADDR_MODE0 = 8'hDA;
    localparam logic [7:0] CAP_ADDR_CMPL0 = 8'hEA;
    localparam logic [7:0] CAP_ADDR_CMPH0 = 8'hFA;
    localparam logic [7:0] CAP_ADDR_CNTL = 8'hE9;
    localparam logic [7:0] CAP_ADDR_CNTH = 8'hF9;
    localparam logic [7:0] CAP_ADDR_WDOG = 8'hD9;
    localparam logic [7:0] CAP_ADDR_RUN = 8'hDF;
    localparam int CAP_BIT_COMPARE_ENABLE = 6;
    localparam int CAP_BIT_MATCH_ENABLE = 3;
    localparam int CAP_BIT_TOGGLE_ENABLE = 2;
    localparam int CAP_BIT_PWM_ENABLE = 1;
    localparam int CAP_BIT_IRQ_ENABLE = 0;
    localparam int CAP_BIT_WDOG_ENABLE = 0;
    localparam logic [6:0] CAP_MODE_RESET = 7'h00;
    localparam logic [7:0] CAP_BYTE_RESET = 8'h00;
    localparam logic [15:0] CAP_COUNT_RESET = 16'h0000;
    localparam logic [7:0] CAP_LOW_WRAP = 8'hFF;
    localparam logic [7:0] CAP_PRESCALE_RESET = 8'h00;

    typedef struct packed {
        logic compare_enable;
        logic match_enable;
        logic toggle_enable;
        logic pwm_enable;
        logic match_irq_enable;
    } cap_mode_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cap_bus_s;
endpackage : cap_pkg

// *** hw/cap_channel.sv ***
`timescale 1ns/100ps
module cap_channel
    import cap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cap_mode_s mode,
    input wire logic [15:0] count,
    input wire logic tick,
    input wire logic low_wrap,
    input wire logic [15:0] compare_value,
    output logic match,
    output logic module_output_pin
);
    logic [7:0] duty_active_byte;
    logic hit;

    // exact 16-bit equality, one event per increment
    assign hit = (count == compare_value);
    assign match = tick && hit && mode.compare_enable && mode.match_enable;

    // glitch-free duty reload on low byte wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_active_byte <= CAP_BYTE_RESET;
        end else if (low_wrap) begin
            duty_active_byte <= compare_value[15:8];
        end
    end

    // output pin: pwm comparator or toggle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            module_output_pin <= 1'b0;
        end else if (mode.pwm_enable && mode.compare_enable) begin
            module_output_pin <= (count[7:0] >= duty_active_byte);
        end else if (match && mode.toggle_enable) begin
            module_output_pin <= ~module_output_pin;
        end
    end
endmodule : cap_channel

// *** hw/cap_array.sv ***
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
module cap_array
    import cap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    output logic watchdog_reset,
    output logic [CAP_MODULES-1:0] module_output_pin
);
    cap_bus_s bus;
    cap_mode_s module_mode_reg [CAP_MODULES];
    logic [7:0] compare_low_byte [CAP_MODULES];
    logic [7:0] compare_high_byte [CAP_MODULES];
    logic [CAP_MODULES-1:0] module_match_flag;
    logic [CAP_MODULES-1:0] match;
    logic [7:0] counter_low_byte;
    logic [7:0] counter_high_byte;
    logic [7:0] prescale;
    logic [7:0] prescale_count;
    logic counter_run;
    logic watchdog_enable;
    logic tick;
    logic low_wrap;
    logic [7:0] next_rdata;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        in_bank = (a >= base) && (d < 8'(CAP_MODULES));
    endfunction : in_bank

    function automatic logic [7:0] mode_to_byte(input cap_mode_s m);
        logic [7:0] b;
        b = CAP_BYTE_RESET;
        b[CAP_BIT_COMPARE_ENABLE] = m.compare_enable;
        b[CAP_BIT_MATCH_ENABLE] = m.match_enable;
        b[CAP_BIT_TOGGLE_ENABLE] = m.toggle_enable;
        b[CAP_BIT_PWM_ENABLE] = m.pwm_enable;
        b[CAP_BIT_IRQ_ENABLE] = m.match_irq_enable;
        mode_to_byte = b;
    endfunction : mode_to_byte

    // count rate: one increment per (prescale + 1) clocks
    assign tick = counter_run && (prescale_count == prescale);
    assign low_wrap = tick && (counter_low_byte == CAP_LOW_WRAP);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_count <= CAP_PRESCALE_RESET;
        end else if (!counter_run || tick) begin
            prescale_count <= CAP_PRESCALE_RESET;
        end else begin
            prescale_count <= prescale_count + 8'h01;
        end
    end

    // shared time base
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_low_byte <= CAP_COUNT_RESET[7:0];
            counter_high_byte <= CAP_COUNT_RESET[15:8];
        end else if (bus.wr && bus.addr == CAP_ADDR_CNTL) begin
            counter_low_byte <= bus.wdata;
        end else if (bus.wr && bus.addr == CAP_ADDR_CNTH) begin
            counter_high_byte <= bus.wdata;
        end else if (tick) begin
            {counter_high_byte, counter_low_byte} <= {counter_high_byte, counter_low_byte}
                + 16'h0001;
        end
    end

    // global controls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_run <= 1'b0;
            prescale <= CAP_PRESCALE_RESET;
            watchdog_enable <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == CAP_ADDR_RUN) begin
                prescale <= bus.wdata;
            end
            if (bus.wr && bus.addr == CAP_ADDR_CTRL) begin
                counter_run <= bus.wdata[CAP_BIT_COMPARE_ENABLE];
            end
            if (bus.wr && bus.addr == CAP_ADDR_WDOG) begin
                watchdog_enable <= bus.wdata[CAP_BIT_WDOG_ENABLE];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < CAP_MODULES; gi++) begin : g_mod
            localparam logic [7:0] IDX = 8'(gi);
            logic wr_mode;
            logic wr_low;
            logic wr_high;
            assign wr_mode = bus.wr && (bus.addr == CAP_ADDR_MODE0 + IDX);
            assign wr_low = bus.wr && (bus.addr == CAP_ADDR_CMPL0 + IDX);
            assign wr_high = bus.wr && (bus.addr == CAP_ADDR_CMPH0 + IDX);

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    module_mode_reg[gi] <= cap_mode_s'(CAP_MODE_RESET[4:0]);
                end else if (wr_mode) begin
                    module_mode_reg[gi].compare_enable <=
                        bus.wdata[CAP_BIT_COMPARE_ENABLE];
                    module_mode_reg[gi].match_enable <= bus.wdata[CAP_BIT_MATCH_ENABLE];
                    module_mode_reg[gi].toggle_enable <= bus.wdata[CAP_BIT_TOGGLE_ENABLE];
                    module_mode_reg[gi].pwm_enable <= bus.wdata[CAP_BIT_PWM_ENABLE];
                    module_mode_reg[gi].match_irq_enable <= bus.wdata[CAP_BIT_IRQ_ENABLE];
                end else if (wr_high) begin
                    module_mode_reg[gi].compare_enable <= 1'b1;
                end else if (wr_low) begin
                    module_mode_reg[gi].compare_enable <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    compare_low_byte[gi] <= CAP_BYTE_RESET;
                    compare_high_byte[gi] <= CAP_BYTE_RESET;
                end else begin
                    if (wr_low) begin
                        compare_low_byte[gi] <= bus.wdata;
                    end
                    if (wr_high) begin
                        compare_high_byte[gi] <= bus.wdata;
                    end
                end
            end

            // flag: set wins over software clear
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    module_match_flag[gi] <= 1'b0;
                end else if (match[gi]) begin
                    module_match_flag[gi] <= 1'b1;
                end else if (bus.wr && bus.addr == CAP_ADDR_CTRL && !bus.wdata[gi]) begin
                    module_match_flag[gi] <= 1'b0;
                end
            end

            cap_channel u_channel (
                .clk(clk),
                .rst_n(rst_n),
                .mode(module_mode_reg[gi]),
                .count({counter_high_byte, counter_low_byte}),
                .tick(tick),
                .low_wrap(low_wrap),
                .compare_value({compare_high_byte[gi], compare_low_byte[gi]}),
                .match(match[gi]),
                .module_output_pin(module_output_pin[gi])
            );
        end
    endgenerate

    // interrupt request: flag and enable together
    always_comb begin
        irq = 1'b0;
        for (int i = 0; i < CAP_MODULES; i++) begin
            irq = irq | (module_match_flag[i] & module_mode_reg[i].match_irq_enable);
        end
    end

    // internal reset pulse only, no pin drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= watchdog_enable && match[CAP_WDOG_MODULE];
        end
    end

    // read mux
    always_comb begin
        next_rdata = CAP_BYTE_RESET;
        if (bus.addr == CAP_ADDR_CTRL) begin
            next_rdata = {1'b0, counter_run, 1'b0, module_match_flag};
        end else if (bus.addr == CAP_ADDR_CNTL) begin
            next_rdata = counter_low_byte;
        end else if (bus.addr == CAP_ADDR_CNTH) begin
            next_rdata = counter_high_byte;
        end else if (bus.addr == CAP_ADDR_WDOG) begin
            next_rdata = {7'h00, watchdog_enable};
        end else if (bus.addr == CAP_ADDR_RUN) begin
            next_rdata = prescale;
        end else if (in_bank(bus.addr, CAP_ADDR_MODE0)) begin
            next_rdata = mode_to_byte(module_mode_reg[3'(bus.addr - CAP_ADDR_MODE0)]);
        end else if (in_bank(bus.addr, CAP_ADDR_CMPL0)) begin
            next_rdata = compare_low_byte[3'(bus.addr - CAP_ADDR_CMPL0)];
        end else if (in_bank(bus.addr, CAP_ADDR_CMPH0)) begin
            next_rdata = compare_high_byte[3'(bus.addr - CAP_ADDR_CMPH0)];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= CAP_BYTE_RESET;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= CAP_BYTE_RESET;
        end
    end
endmodule : cap_array

// *** testbench/cap_array_properties.sv ***
`timescale 1ns/100ps
module cap_array_chk
    import cap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic watchdog_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic wdog_on;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_on <= 1'b0;
        end else if (wr && addr == CAP_ADDR_WDOG) begin
            wdog_on <= wdata[CAP_BIT_WDOG_ENABLE];
        end
    end
    sequence rd_at(logic [7:0] a);
        rd && addr == a;
    endsequence
    sequence wr_at(logic [7:0] a);
        wr && addr == a;
    endsequence
    for (genvar i = 0; i < CAP_MODULES; i++) begin : g_mod
        localparam logic [7:0] M = CAP_ADDR_MODE0 + 8'(i);
        localparam logic [7:0] H = CAP_ADDR_CMPH0 + 8'(i);
        localparam logic [7:0] L = CAP_ADDR_CMPL0 + 8'(i);
        hi_sets_a: assert property (wr_at(H) ##1 rd_at(M) |=> rdata[6])
            else $error("compare enable not set");
        lo_clears_a: assert property (wr_at(L) ##1 rd_at(M) |=> !rdata[6])
            else $error("compare enable not cleared");
    end
    lo_hi_a: assert property (wr_at(CAP_ADDR_CMPL0) ##1 wr_at(CAP_ADDR_CMPH0) ##1
        rd_at(CAP_ADDR_MODE0) |=> rdata[6]) else $error("compare not re-enabled");
    mode_echo_a: assert property (wr_at(CAP_ADDR_MODE0) ##1 rd_at(CAP_ADDR_MODE0)
        |=> rdata[6] == $past(wdata[6], 2)) else $error("compare enable not echoed");
    mode_rsvd_a: assert property (rd_at(CAP_ADDR_MODE0) |=> rdata[7] == 1'b0
        && rdata[5:4] == 2'b00) else $error("mode spare bits set");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without read");
    wd_single_a: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("watchdog pulse too long");
    wd_armed_a: assert property (watchdog_reset |-> $past(wdog_on))
        else $error("watchdog fired while disabled");
endmodule : cap_array_chk

bind cap_array cap_array_chk u_chk (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .watchdog_reset);

// *** testbench/cap_array_tb.sv ***
`timescale 1ns/100ps
module testbench
    import cap_pkg::*;
    ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata;
    logic irq;
    logic watchdog_reset;
    logic [CAP_MODULES-1:0] module_output_pin;
    wire [5:0] obs = {watchdog_reset, module_output_pin};
    logic [7:0] exp_q[$];
    logic [7:0] d0, d3;
    int err_count = 0;
    int checks = 0;
    int seed = 79818;
    int n, m;
    always #4 clk = ~clk;
    cap_array uut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .irq, .watchdog_reset,
        .module_output_pin);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : bus
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        bus(1'b0, 1'b1, a, 8'($random(seed)));
    endtask : rreg
    task automatic idle(input int k);
        repeat (k) bus(1'b0, 1'b0, 8'($random(seed)), 8'($random(seed)));
    endtask : idle
    task automatic set_count(input logic [15:0] v);
        wreg(CAP_ADDR_CTRL, 8'h00);
        wreg(CAP_ADDR_CNTH, v[15:8]);
        wreg(CAP_ADDR_CNTL, v[7:0]);
        wreg(CAP_ADDR_CTRL, 8'h40);
    endtask : set_count
    task automatic set_cmp(input int i, input logic [15:0] v);
        wreg(CAP_ADDR_CMPL0 + 8'(i), v[7:0]);
        wreg(CAP_ADDR_CMPH0 + 8'(i), v[15:8]);
    endtask : set_cmp
    task automatic watch(input int k, input int j, output int hi, output int tg);
        logic last;
        hi = 0;
        tg = 0;
        last = obs[j];
        repeat (k) begin
            idle(1);
            hi += int'(obs[j] === 1'b1);
            tg += int'(obs[j] !== last);
            last = obs[j];
        end
    endtask : watch
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        if (rd_q) begin
            check("rdata", rdata, exp_q.pop_front());
        end
        rd_q <= rd;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        idle(1);
        rreg(CAP_ADDR_CNTL, 8'h00);
        rreg(CAP_ADDR_CNTH, 8'h00);
        rreg(8'h00, 8'h00);
        for (int i = 0; i < CAP_MODULES; i++) begin
            rreg(CAP_ADDR_MODE0 + 8'(i), 8'h00);
            wreg(CAP_ADDR_MODE0 + 8'(i), 8'hFF);
            rreg(CAP_ADDR_MODE0 + 8'(i), 8'h4F);
            wreg(CAP_ADDR_CMPL0 + 8'(i), 8'h34);
            rreg(CAP_ADDR_MODE0 + 8'(i), 8'h0F);
            wreg(CAP_ADDR_CMPH0 + 8'(i), 8'h12);
            rreg(CAP_ADDR_MODE0 + 8'(i), 8'h4F);
            rreg(CAP_ADDR_CMPL0 + 8'(i), 8'h34);
            wreg(CAP_ADDR_MODE0 + 8'(i), 8'h00);
            rreg(CAP_ADDR_MODE0 + 8'(i), 8'h00);
        end
        set_cmp(0, 16'h0001);
        rreg(CAP_ADDR_MODE0, 8'h40);
        set_cmp(1, 16'h0105);
        for (int e = 0; e < 2; e++) begin
            wreg(CAP_ADDR_MODE0 + 8'h01, 8'h48 | 8'(e));
            set_count(16'h0100);
            idle(20);
            check("irq", irq, 16'(e));
            rreg(CAP_ADDR_CTRL, 8'h42);
        end
        set_cmp(4, 16'h0220);
        wreg(CAP_ADDR_MODE0 + 8'h04, 8'h48);
        for (int e = 0; e < 3; e++) begin
            wreg(CAP_ADDR_WDOG, {7'h00, e != 1});
            set_count(16'h0210);
            watch(40, 5, n, m);
            check("watchdog pulses", 16'(n), 16'(e != 1));
        end
        set_count(16'h0210);
        set_cmp(4, 16'h0250);
        watch(40, 5, n, m);
        check("watchdog held off", 16'(n), 16'h0000);
        wreg(CAP_ADDR_WDOG, 8'h00);
        set_cmp(2, 16'h0305);
        for (int e = 0; e < 2; e++) begin
            wreg(CAP_ADDR_MODE0 + 8'h02, (e != 0) ? 8'h48 : 8'h4C);
            set_count(16'h0300);
            watch(30, 2, n, m);
            check("toggles", 16'(m), 16'(1 - e));
        end
        for (int e = 0; e < 2; e++) begin
            d3 = 8'($random(seed));
            d0 = 8'($random(seed));
            wreg(CAP_ADDR_CMPH0 + 8'h03, d3);
            wreg(CAP_ADDR_CMPH0, d0);
            wreg(CAP_ADDR_MODE0 + 8'h03, 8'h42);
            wreg(CAP_ADDR_MODE0, 8'h42);
            set_count(16'h00F0);
            idle(20);
            watch(256, 3, n, m);
            check("pwm high 3", 16'(n), 16'h0100 - 16'(d3));
            watch(256, 0, n, m);
            check("pwm high 0", 16'(n), 16'h0100 - 16'(d0));
        end
        wreg(CAP_ADDR_RUN, 8'h03);
        set_count(16'h0000);
        idle(8);
        rreg(CAP_ADDR_CNTL, 8'h02);
        rreg(CAP_ADDR_RUN, 8'h03);
        idle(1);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(1);
        rreg(CAP_ADDR_CNTL, 8'h00);
        rreg(CAP_ADDR_RUN, 8'h00);
        rreg(CAP_ADDR_MODE0 + 8'h03, 8'h00);
        idle(2);
        give_verdict();
    end
endmodule : testbench
